// File: verilog/xcvr_status_and_tx_switch_regs.sv
// management register bank: lane 3 error counter, status flags, tx switch control
`timescale 1ns/100ps
module xcvr_status_and_tx_switch_regs #(
   parameter logic [4:0] PORT_ADDR = 5'h00
) (
   // clock and reset
   input  wire logic                        i_ref_clk,
   input  wire logic                        i_nrst,
   // management pins
   input  wire logic                        i_mdc,
   input  wire logic                        i_mdio,
   output logic                             o_mdio_out,
   output logic                             o_mdio_oe,
   // mode and neighbouring configuration
   input  wire xcvr_mgmt_pkg::mode_t        i_mode,
   input  wire logic                        i_ls_test_verify,
   input  wire logic [1:0]                  i_test_pattern_select,
   input  wire logic [1:0]                  i_low_side_status_lane_select,
   input  wire logic                        i_addr_pin_switch_enable,
   input  wire logic                        i_addr_pin_channel_assign,
   input  wire logic [1:0]                  i_tx_switch_sw_src,
   input  wire logic                        i_port_address_bit0_pin,
   // lane 3 error events
   input  wire logic                        i_lane3_decode_err,
   input  wire logic                        i_lane3_align_decode_err,
   input  wire logic [3:0]                  i_lane3_pattern_err,
   // low side status sources
   input  wire logic [3:0]                  i_lane_bad_decode,
   input  wire logic [3:0]                  i_lane_signal_loss,
   input  wire logic [3:0]                  i_lane_sync,
   input  wire logic                        i_align_fifo_fault,
   input  wire logic [3:0]                  i_low_side_sync_rotation,
   // high side status sources
   input  wire logic [6:0]                  i_high_side_sync_rotation,
   input  wire logic [2:0]                  i_high_side_sync_state,
   // tx switch control outputs
   output logic [1:0]                       o_tx_switch_src,
   output xcvr_mgmt_pkg::off_trig_t         o_tx_switch_off_trigger,
   output logic [31:0]                      o_kr_off_pattern
);

   // pin synchronisers: first stage feeds only the second
   logic       mdc_meta;
   logic       mdc_sync;
   logic       mdc_prev;
   logic       mdio_meta;
   logic       mdio_sync;
   logic       pin_meta;
   logic       pin_sync;

   // frame engine
   xcvr_mgmt_pkg::mdio_state_t state;
   xcvr_mgmt_pkg::mdio_state_t next_state;
   logic [5:0]  pre_count;
   logic [4:0]  bit_count;
   logic [12:0] header;
   logic [15:0] data_shift;
   logic [15:0] addr_reg;

   // registers
   logic [15:0] lane3_code_err_count;
   logic [15:0] tx_switch_control_a;
   logic        low_side_bad_decode_flag;
   logic        low_side_signal_loss_flag;
   logic        low_side_align_fifo_fault;
   logic        low_side_sync_flag;

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         mdc_meta  <= 1'b0;
         mdc_sync  <= 1'b0;
         mdc_prev  <= 1'b0;
         mdio_meta <= 1'b1;
         mdio_sync <= 1'b1;
         pin_meta  <= 1'b0;
         pin_sync  <= 1'b0;
      end else begin
         mdc_meta  <= i_mdc;
         mdc_sync  <= mdc_meta;
         mdc_prev  <= mdc_sync;
         mdio_meta <= i_mdio;
         mdio_sync <= mdio_meta;
         pin_meta  <= i_port_address_bit0_pin;
         pin_sync  <= pin_meta;
      end
   end

   // frame field decode
   wire       mdc_rise   = mdc_sync & ~mdc_prev;
   wire       bit_tick   = mdc_rise && (state == xcvr_mgmt_pkg::ST_FRAME);
   wire       st1_ok     = ~header[12];
   wire [1:0] op         = header[11:10];
   wire [4:0] prt_addr   = header[9:5];
   wire [4:0] dev_addr   = header[4:0];
   wire       for_us     = st1_ok && (prt_addr == PORT_ADDR) &&
                           (dev_addr == xcvr_mgmt_pkg::DEVICE_ADDR);
   wire       is_read    = (op == xcvr_mgmt_pkg::OP_READ) ||
                           (op == xcvr_mgmt_pkg::OP_READ_INC);
   wire       frame_done = bit_tick && (bit_count == xcvr_mgmt_pkg::BIT_LAST);
   wire       frame_start = mdc_rise && (state == xcvr_mgmt_pkg::ST_IDLE) &&
                           !mdio_sync && (pre_count == xcvr_mgmt_pkg::PREAMBLE_LEN);

   // read strobe at first turnaround bit: data is captured and side effects fire
   wire       rd_strobe  = bit_tick && for_us && is_read &&
                           (bit_count == xcvr_mgmt_pkg::BIT_TA0);
   wire       wr_commit  = frame_done && for_us && (op == xcvr_mgmt_pkg::OP_WRITE);
   wire       adr_commit = frame_done && for_us && (op == xcvr_mgmt_pkg::OP_ADDRESS);
   wire [15:0] wr_data   = {data_shift[14:0], mdio_sync};

   // register selects
   wire sel_err = (addr_reg == xcvr_mgmt_pkg::ADDR_ERR_COUNT);
   wire sel_ls  = (addr_reg == xcvr_mgmt_pkg::ADDR_LS_STATUS);
   wire sel_hs  = (addr_reg == xcvr_mgmt_pkg::ADDR_HS_STATUS);
   wire sel_tx  = (addr_reg == xcvr_mgmt_pkg::ADDR_TX_SWITCH);
   wire rd_err  = rd_strobe && sel_err;
   wire rd_ls   = rd_strobe && sel_ls;

   // frame state machine
   always_comb begin
      next_state = state;
      case (state)
         xcvr_mgmt_pkg::ST_IDLE: begin
            if (frame_start) begin
               next_state = xcvr_mgmt_pkg::ST_FRAME;
            end
         end
         xcvr_mgmt_pkg::ST_FRAME: begin
            if (frame_done) begin
               next_state = xcvr_mgmt_pkg::ST_IDLE;
            end
         end
         default: next_state = xcvr_mgmt_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state <= xcvr_mgmt_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // preamble: count ones, a zero before 32 of them restarts the hunt
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pre_count <= 6'h00;
      end else if (state != xcvr_mgmt_pkg::ST_IDLE) begin
         pre_count <= 6'h00;
      end else if (mdc_rise) begin
         if (!mdio_sync) begin
            pre_count <= 6'h00;
         end else if (pre_count != xcvr_mgmt_pkg::PREAMBLE_LEN) begin
            pre_count <= pre_count + 6'h01;
         end
      end
   end

   // bit position within the frame, start bit is position 0
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         bit_count <= 5'h00;
      end else if (frame_start) begin
         bit_count <= 5'h01;
      end else if (bit_tick) begin
         bit_count <= bit_count + 5'h01;
      end
   end

   // header bits collect up to the turnaround
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         header <= 13'h0000;
      end else if (bit_tick && (bit_count <= xcvr_mgmt_pkg::BIT_HDR_END)) begin
         header <= {header[11:0], mdio_sync};
      end
   end

   // read data image of the addressed register
   logic [15:0] rd_data;
   wire  [15:0] ls_image;
   wire  [15:0] hs_image;
   wire  [2:0]  hs_upper;

   assign ls_image = {4'h0, low_side_bad_decode_flag, low_side_signal_loss_flag,
                      low_side_align_fifo_fault, low_side_sync_flag,
                      4'h0, i_low_side_sync_rotation};
   assign hs_upper = (i_mode == xcvr_mgmt_pkg::MODE_KR) ?
                     i_high_side_sync_rotation[6:4] : i_high_side_sync_state;
   assign hs_image = {9'h000, hs_upper, i_high_side_sync_rotation[3:0]};

   always_comb begin
      rd_data = 16'h0000;
      if (sel_err) begin
         rd_data = lane3_code_err_count;
      end else if (sel_ls) begin
         rd_data = ls_image;
      end else if (sel_hs) begin
         rd_data = hs_image;
      end else if (sel_tx) begin
         rd_data = tx_switch_control_a;
      end
   end

   // data shift: serves read output and write capture
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         data_shift <= 16'h0000;
      end else if (rd_strobe) begin
         data_shift <= rd_data;
      end else if (bit_tick && (bit_count > xcvr_mgmt_pkg::BIT_TA0)) begin
         data_shift <= wr_data;
      end
   end

   // pin drive: zero on second turnaround bit, then data msb first
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_mdio_oe  <= 1'b0;
         o_mdio_out <= 1'b1;
      end else if (rd_strobe) begin
         o_mdio_oe  <= 1'b1;
         o_mdio_out <= 1'b0;
      end else if (frame_done) begin
         o_mdio_oe  <= 1'b0;
         o_mdio_out <= 1'b1;
      end else if (bit_tick && o_mdio_oe) begin
         o_mdio_out <= data_shift[15];
      end
   end

   // address register; read with increment advances after the frame
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         addr_reg <= 16'h0000;
      end else if (adr_commit) begin
         addr_reg <= wr_data;
      end else if (frame_done && for_us && (op == xcvr_mgmt_pkg::OP_READ_INC)) begin
         addr_reg <= addr_reg + 16'h0001;
      end
   end

   // lane 3 error source chosen by mode
   wire lane3_err_event = i_ls_test_verify ?
                          i_lane3_pattern_err[i_test_pattern_select] :
                          (i_mode == xcvr_mgmt_pkg::MODE_10G) ?
                          i_lane3_align_decode_err :
                          ((i_mode == xcvr_mgmt_pkg::MODE_KR) ||
                           (i_mode == xcvr_mgmt_pkg::MODE_KX)) ?
                          i_lane3_decode_err : 1'b0;
   wire cnt_at_max = (lane3_code_err_count == xcvr_mgmt_pkg::ERR_COUNT_MAX);

   // saturating counter; an error in the read cycle survives the clear
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         lane3_code_err_count <= xcvr_mgmt_pkg::ERR_COUNT_RESET;
      end else if (rd_err) begin
         lane3_code_err_count <= {15'h0000, lane3_err_event};
      end else if (lane3_err_event && !cnt_at_max) begin
         lane3_code_err_count <= lane3_code_err_count + 16'h0001;
      end
   end

   // live conditions of the selected lane
   wire lane_bad_decode = i_lane_bad_decode[i_low_side_status_lane_select];
   wire lane_sig_loss   = i_lane_signal_loss[i_low_side_status_lane_select];
   wire lane_sync       = i_lane_sync[i_low_side_status_lane_select];

   // latched flags: a live condition always wins over a read clear
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         low_side_bad_decode_flag  <= 1'b0;
         low_side_signal_loss_flag <= 1'b0;
         low_side_align_fifo_fault <= 1'b0;
         low_side_sync_flag        <= 1'b0;
      end else if (rd_ls) begin
         low_side_bad_decode_flag  <= lane_bad_decode;
         low_side_signal_loss_flag <= lane_sig_loss;
         low_side_align_fifo_fault <= i_align_fifo_fault;
         low_side_sync_flag        <= lane_sync;
      end else begin
         low_side_bad_decode_flag  <= low_side_bad_decode_flag | lane_bad_decode;
         low_side_signal_loss_flag <= low_side_signal_loss_flag | lane_sig_loss;
         low_side_align_fifo_fault <= low_side_align_fifo_fault | i_align_fifo_fault;
         low_side_sync_flag        <= low_side_sync_flag & lane_sync;
      end
   end

   // tx switch control, all 16 bits writable
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tx_switch_control_a <= xcvr_mgmt_pkg::TX_SWITCH_RESET;
      end else if (wr_commit && sel_tx) begin
         tx_switch_control_a <= wr_data;
      end
   end

   // source select: pin path needs all three enables, else software field
   wire       pin_mode = tx_switch_control_a[xcvr_mgmt_pkg::SW_PIN_EN_BIT] &&
                         i_addr_pin_switch_enable && i_addr_pin_channel_assign;
   wire [1:0] src_hi   = tx_switch_control_a[xcvr_mgmt_pkg::SW_SRC_HI_MSB:
                                             xcvr_mgmt_pkg::SW_SRC_HI_LSB];
   wire [1:0] src_lo   = tx_switch_control_a[xcvr_mgmt_pkg::SW_SRC_LO_MSB:
                                             xcvr_mgmt_pkg::SW_SRC_LO_LSB];
   wire [1:0] src_pin  = pin_sync ? src_hi : src_lo;
   wire [1:0] next_src = pin_mode ? src_pin : i_tx_switch_sw_src;

   // off trigger: bit 7 picks the trigger kind only in kr and kx; the kr off pattern follows it in every mode
   wire off_sel = tx_switch_control_a[xcvr_mgmt_pkg::SW_OFF_SEL_BIT];
   xcvr_mgmt_pkg::off_trig_t next_off;
   always_comb begin
      case (i_mode)
         xcvr_mgmt_pkg::MODE_KR:
            next_off = off_sel ? xcvr_mgmt_pkg::OFF_KR_FAULT :
                                 xcvr_mgmt_pkg::OFF_KR_IDLE;
         xcvr_mgmt_pkg::MODE_KX:
            next_off = off_sel ? xcvr_mgmt_pkg::OFF_KX_CHAR :
                                 xcvr_mgmt_pkg::OFF_KX_IDLE;
         default:
            next_off = xcvr_mgmt_pkg::OFF_NONE;
      endcase
   end

   // registered switch outputs; one cycle behind the control register
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_tx_switch_src         <= 2'h0;
         o_tx_switch_off_trigger <= xcvr_mgmt_pkg::OFF_NONE;
         o_kr_off_pattern        <= xcvr_mgmt_pkg::KR_IDLE_WORD;
      end else begin
         o_tx_switch_src         <= next_src;
         o_tx_switch_off_trigger <= next_off;
         o_kr_off_pattern        <= off_sel ? xcvr_mgmt_pkg::KR_LOCAL_FAULT :
                                              xcvr_mgmt_pkg::KR_IDLE_WORD;
      end
   end

endmodule

// File: verilog/xcvr_mgmt_pkg.sv
// constants and types for the transceiver status and tx switch register bank
package xcvr_mgmt_pkg;

   // functional modes of the channel
   typedef enum logic [1:0] {
      MODE_10G     = 2'h0,
      MODE_KR      = 2'h1,
      MODE_KX      = 2'h2,
      MODE_GENERIC = 2'h3
   } mode_t;

   // off trigger kinds handed to the data switch
   typedef enum logic [2:0] {
      OFF_NONE     = 3'h0,
      OFF_KR_FAULT = 3'h1,
      OFF_KR_IDLE  = 3'h2,
      OFF_KX_CHAR  = 3'h3,
      OFF_KX_IDLE  = 3'h4
   } off_trig_t;

   // management frame engine states
   typedef enum logic [0:0] {
      ST_IDLE  = 1'h0,
      ST_FRAME = 1'h1
   } mdio_state_t;

   // register addresses inside the device
   localparam logic [15:0] ADDR_ERR_COUNT = 16'h0014;
   localparam logic [15:0] ADDR_LS_STATUS = 16'h0015;
   localparam logic [15:0] ADDR_HS_STATUS = 16'h0016;
   localparam logic [15:0] ADDR_TX_SWITCH = 16'h0017;
   localparam logic [4:0]  DEVICE_ADDR    = 5'h1e;

   // reset values and counter ceiling
   localparam logic [15:0] ERR_COUNT_RESET = 16'hfffd;
   localparam logic [15:0] ERR_COUNT_MAX   = 16'hffff;
   localparam logic [15:0] TX_SWITCH_RESET = 16'h2000;

   // status field positions
   localparam int LS_BAD_DECODE_BIT = 11;
   localparam int LS_SIG_LOSS_BIT   = 10;
   localparam int LS_FIFO_FAULT_BIT = 9;
   localparam int LS_SYNC_BIT       = 8;

   // tx switch control field positions
   localparam int SW_PIN_EN_BIT  = 12;
   localparam int SW_SRC_HI_MSB  = 11;
   localparam int SW_SRC_HI_LSB  = 10;
   localparam int SW_SRC_LO_MSB  = 9;
   localparam int SW_SRC_LO_LSB  = 8;
   localparam int SW_OFF_SEL_BIT = 7;

   // kr off trigger words
   localparam logic [31:0] KR_LOCAL_FAULT = 32'h0100009c;
   localparam logic [31:0] KR_IDLE_WORD   = 32'h07070707;

   // management frame layout and opcodes
   localparam logic [5:0] PREAMBLE_LEN  = 6'h20;
   localparam logic [4:0] BIT_ST1       = 5'h01;
   localparam logic [4:0] BIT_OP_LSB    = 5'h03;
   localparam logic [4:0] BIT_HDR_END   = 5'h0d;
   localparam logic [4:0] BIT_TA0       = 5'h0e;
   localparam logic [4:0] BIT_LAST      = 5'h1f;
   localparam logic [1:0] OP_ADDRESS    = 2'h0;
   localparam logic [1:0] OP_WRITE      = 2'h1;
   localparam logic [1:0] OP_READ_INC   = 2'h2;
   localparam logic [1:0] OP_READ       = 2'h3;

endpackage

// File: tb/xcvr_mdio_station.sv
// management station model: drives mdc and mdio frames, samples read data
`timescale 1ns/100ps
module xcvr_mdio_station #(
   parameter int HALF = 6
) (
   // clock
   input  wire logic i_clk,
   // block side of the management pin
   input  wire logic i_mdio_out,
   input  wire logic i_mdio_oe,
   // resolved management pins
   output logic      o_mdc,
   output logic      o_mdio
);
   logic drv_en;
   logic drv_d;

   // a released line floats high through its pull-up
   assign o_mdio = i_mdio_oe ? i_mdio_out : (drv_en ? drv_d : 1'b1);

   initial begin
      o_mdc  = 1'b0;
      drv_en = 1'b0;
      drv_d  = 1'b1;
   end

   // one frame with fresh preamble; mdc stands low between frames
   task automatic frame(input logic [1:0] op, input logic [4:0] prt,
                        input logic [15:0] wd, output logic [15:0] rd);
      logic [63:0] bits;
      bits = {32'hffffffff, 2'h0, op, prt, xcvr_mgmt_pkg::DEVICE_ADDR, 2'h2, wd};
      rd = 16'h0000;
      for (int i = 0; i < 64; i++) begin
         @(negedge i_clk);
         o_mdc  = 1'b0;
         drv_en = !(op[1] && i >= 46); // let go from turnaround on reads
         drv_d  = bits[63 - i];
         repeat (HALF) @(negedge i_clk);
         o_mdc = 1'b1;
         if (i >= 48)
            rd = {rd[14:0], o_mdio}; // bit still stands at this rise
         repeat (HALF - 1) @(negedge i_clk);
      end
      @(negedge i_clk);
      o_mdc  = 1'b0;
      drv_en = 1'b0;
   endtask
endmodule

// File: tb/xcvr_status_and_tx_switch_regs_chk.sv
// assertions on the management pin drive and tx switch outputs
`timescale 1ns/100ps
module xcvr_status_and_tx_switch_regs_chk (
   // clock and reset
   input  wire logic                     i_ref_clk,
   input  wire logic                     i_nrst,
   // watched inputs
   input  wire logic                     i_mdc,
   input  wire xcvr_mgmt_pkg::mode_t     i_mode,
   input  wire logic                     i_addr_pin_switch_enable,
   input  wire logic [1:0]               i_tx_switch_sw_src,
   // watched outputs
   input  wire logic                     o_mdio_out,
   input  wire logic                     o_mdio_oe,
   input  wire logic [1:0]               o_tx_switch_src,
   input  wire xcvr_mgmt_pkg::off_trig_t o_tx_switch_off_trigger,
   input  wire logic [31:0]              o_kr_off_pattern
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   logic up;

   // past values are trusted only from the second edge after reset
   always_ff @(posedge i_ref_clk or negedge i_nrst)
      if (!i_nrst)
         up <= 1'b0;
      else
         up <= 1'b1;

   // answer starts only after mdc has been high a while
   sequence s_mdc_high;
      $past(i_mdc, 2) && $past(i_mdc);
   endsequence
   // mdc is slow, so the pin is held well over 8 cycles, then released
   sequence s_drive;
      o_mdio_oe[*8] ##[1:1000] !o_mdio_oe;
   endsequence
   sequence s_kr_cycle;
      up && $past(i_mode) == xcvr_mgmt_pkg::MODE_KR;
   endsequence

   a_ta_low: assert property ($rose(o_mdio_oe) |-> !o_mdio_out)
      else $error("answer does not open with a zero");
   a_oe_after_mdc: assert property ($rose(o_mdio_oe) |-> s_mdc_high)
      else $error("pin driven without a management clock rise");
   a_drive_bounded: assert property ($rose(o_mdio_oe) |-> s_drive)
      else $error("pin drive too short or never released");
   a_sw_src_path: assert property (
      up && !$past(i_addr_pin_switch_enable) |-> o_tx_switch_src == $past(i_tx_switch_sw_src))
      else $error("software source not followed");
   a_kr_pattern_pair: assert property (s_kr_cycle |->
      (o_tx_switch_off_trigger == xcvr_mgmt_pkg::OFF_KR_FAULT)
      == (o_kr_off_pattern == xcvr_mgmt_pkg::KR_LOCAL_FAULT))
      else $error("kr trigger and pattern disagree");
   a_kr_trigger: assert property (s_kr_cycle |-> o_tx_switch_off_trigger inside
      {xcvr_mgmt_pkg::OFF_KR_FAULT, xcvr_mgmt_pkg::OFF_KR_IDLE})
      else $error("wrong trigger kind in kr mode");
   a_kx_trigger: assert property (up && $past(i_mode) == xcvr_mgmt_pkg::MODE_KX |->
      o_tx_switch_off_trigger inside {xcvr_mgmt_pkg::OFF_KX_CHAR, xcvr_mgmt_pkg::OFF_KX_IDLE})
      else $error("wrong trigger kind in kx mode");
   a_no_trigger: assert property (up && $past(i_mode) inside
      {xcvr_mgmt_pkg::MODE_10G, xcvr_mgmt_pkg::MODE_GENERIC}
      |-> o_tx_switch_off_trigger == xcvr_mgmt_pkg::OFF_NONE)
      else $error("trigger set outside kr and kx");
endmodule

bind xcvr_status_and_tx_switch_regs xcvr_status_and_tx_switch_regs_chk chk (
   .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_mdc(i_mdc), .i_mode(i_mode),
   .i_addr_pin_switch_enable(i_addr_pin_switch_enable),
   .i_tx_switch_sw_src(i_tx_switch_sw_src), .o_mdio_out(o_mdio_out),
   .o_mdio_oe(o_mdio_oe), .o_tx_switch_src(o_tx_switch_src),
   .o_tx_switch_off_trigger(o_tx_switch_off_trigger), .o_kr_off_pattern(o_kr_off_pattern));

// File: tb/xcvr_status_and_tx_switch_regs_bench.sv
// self-checking bench for the status and tx switch register bank
`timescale 1ns/100ps
module xcvr_status_and_tx_switch_regs_bench;
   // clock, reset and management pins
   logic                     clk = 1'b0;
   logic                     nrst = 1'b0;
   logic                     mdc, mdio, mdio_out, mdio_oe;
   // stimulus, outputs and bookkeeping
   xcvr_mgmt_pkg::mode_t     mode = xcvr_mgmt_pkg::MODE_KR;
   xcvr_mgmt_pkg::mode_t     modes [4] = '{xcvr_mgmt_pkg::MODE_KR, xcvr_mgmt_pkg::MODE_KX,
                                           xcvr_mgmt_pkg::MODE_10G, xcvr_mgmt_pkg::MODE_KR};
   logic                     tverify, pin_en, pin_asg, pin, dec_err, al_err, fifo;
   logic [1:0]               pat_sel, lane, sw_src, src_o;
   logic [3:0]               pat_err, bad_dec, loss, sync, ls_rot, sel, oth;
   logic [6:0]               hs_rot;
   logic [2:0]               hs_st;
   xcvr_mgmt_pkg::off_trig_t trig_o;
   logic [31:0]              pat_o, r;
   logic [31:0]              seed = 32'h0000bf64;
   logic [15:0]              v, cnt, d;
   int                       n_mismatch = 0, total_checks = 0, cycles = 0;

   always #50 clk = ~clk;

   xcvr_mdio_station #(.HALF(6)) st (.i_clk(clk), .i_mdio_out(mdio_out),
      .i_mdio_oe(mdio_oe), .o_mdc(mdc), .o_mdio(mdio));
   xcvr_status_and_tx_switch_regs dut (
      .i_ref_clk(clk), .i_nrst(nrst), .i_mdc(mdc), .i_mdio(mdio),
      .o_mdio_out(mdio_out), .o_mdio_oe(mdio_oe), .i_mode(mode),
      .i_ls_test_verify(tverify), .i_test_pattern_select(pat_sel),
      .i_low_side_status_lane_select(lane), .i_addr_pin_switch_enable(pin_en),
      .i_addr_pin_channel_assign(pin_asg), .i_tx_switch_sw_src(sw_src),
      .i_port_address_bit0_pin(pin), .i_lane3_decode_err(dec_err),
      .i_lane3_align_decode_err(al_err), .i_lane3_pattern_err(pat_err),
      .i_lane_bad_decode(bad_dec), .i_lane_signal_loss(loss), .i_lane_sync(sync),
      .i_align_fifo_fault(fifo), .i_low_side_sync_rotation(ls_rot),
      .i_high_side_sync_rotation(hs_rot), .i_high_side_sync_state(hs_st),
      .o_tx_switch_src(src_o), .o_tx_switch_off_trigger(trig_o), .o_kr_off_pattern(pat_o));

   // xorshift source, fixed start for repeatable runs
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // expected switch source and off trigger from the control word
   function automatic logic [1:0] src_exp(input logic [15:0] c);
      return (c[12] && pin_en && pin_asg) ? (pin ? c[11:10] : c[9:8]) : sw_src;
   endfunction
   function automatic logic [2:0] trig_exp(input logic b);
      if (mode == xcvr_mgmt_pkg::MODE_KR)
         return b ? xcvr_mgmt_pkg::OFF_KR_FAULT : xcvr_mgmt_pkg::OFF_KR_IDLE;
      if (mode == xcvr_mgmt_pkg::MODE_KX)
         return b ? xcvr_mgmt_pkg::OFF_KX_CHAR : xcvr_mgmt_pkg::OFF_KX_IDLE;
      return xcvr_mgmt_pkg::OFF_NONE;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // register access: address frame, then the data frame
   task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
      logic [15:0] q;
      st.frame(2'h0, 5'h00, a, q);
      st.frame(2'h3, 5'h00, 16'h0000, q);
      chk({16'h0000, q}, {16'h0000, exp});
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] w);
      logic [15:0] q;
      st.frame(2'h0, 5'h00, a, q);
      st.frame(2'h1, 5'h00, w, q);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // hang guard: some 50 frames of about 770 cycles each
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         n_mismatch++;
         stop_test();
      end
   end

   initial begin
      {tverify, pin_en, pin_asg, pin, dec_err, al_err, fifo} = 7'h00;
      {pat_sel, lane, sw_src, pat_err, bad_dec, loss, ls_rot, hs_rot, hs_st} = 32'h0;
      sync = 4'hf;
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      rd_chk(16'h0014, 16'hfffd);
      rd_chk(16'h0014, 16'h0000);
      rd_chk(16'h0017, 16'h2000);
      rd_chk(16'h0015, 16'h0000);
      // lane 3 errors in kr, kx, 10g and pattern verify, with decoys
      for (int k = 0; k < 4; k++) begin
         mode = modes[k];
         tverify = (k == 3);
         r = rnd();
         pat_sel = r[1:0];
         cnt = 16'h0000;
         repeat (150) begin
            @(negedge clk);
            r = rnd();
            {dec_err, al_err, pat_err} = r[5:0];
            cnt += (k == 3) ? pat_err[pat_sel] : (k == 2) ? al_err : dec_err;
         end
         @(negedge clk);
         {dec_err, al_err, pat_err} = 6'h00;
         case (k)
            0, 1: rd_chk(16'h0014, cnt);
            2: rd_chk(16'h0014, cnt);
            default: rd_chk(16'h0014, cnt);
         endcase
      end
      // one-cycle flag events on the chosen lane, noise on the rest
      tverify = 1'b0;
      repeat (2) begin
         r = rnd();
         lane = r[9:8];
         ls_rot = r[13:10];
         sel = 4'h1 << lane;
         oth = r[7:4] & ~sel;
         @(negedge clk);
         bad_dec = (r[0] ? sel : 4'h0) | oth;
         loss = (r[1] ? sel : 4'h0) | oth;
         fifo = r[2];
         sync = ~((r[3] ? sel : 4'h0) | oth);
         @(negedge clk);
         {bad_dec, loss, fifo} = 9'h000;
         sync = 4'hf;
         rd_chk(16'h0015, {4'h0, r[0], r[1], r[2], !r[3], 4'h0, ls_rot});
         wr(16'h0015, 16'hffff);
         rd_chk(16'h0015, {7'h00, 1'b1, 4'h0, ls_rot});
      end
      // high side rotation and state per mode
      for (int k = 0; k < 3; k++) begin
         r = rnd();
         mode = modes[k];
         {hs_st, hs_rot} = r[9:0];
         rd_chk(16'h0016, {9'h000, (k == 0) ? hs_rot[6:4] : hs_st, hs_rot[3:0]});
      end
      // transmit switch control: first word keeps the pin path off
      for (int k = 0; k < 3; k++) begin
         r = rnd();
         v = {r[15:13], k != 0, r[11:0]};
         wr(16'h0017, v);
         rd_chk(16'h0017, v);
         repeat (10) begin
            @(negedge clk);
            r = rnd();
            mode = xcvr_mgmt_pkg::mode_t'(r[1:0]);
            {pin_en, pin_asg} = {r[2] | r[3], r[4] | r[5]};
            pin = r[6];
            sw_src = r[8:7];
            repeat (6) @(negedge clk);
            chk(src_o, src_exp(v));
            chk(trig_o, trig_exp(v[7]));
            chk(pat_o, v[7] ? xcvr_mgmt_pkg::KR_LOCAL_FAULT : xcvr_mgmt_pkg::KR_IDLE_WORD);
         end
      end
      // write to another port address is dropped; unmapped reads zero
      st.frame(2'h1, 5'h01, ~v, d);
      rd_chk(16'h0017, v);
      rd_chk(16'h0030, 16'h0000);
      // read with increment steps from the high side status to the switch word
      st.frame(2'h0, 5'h00, 16'h0016, d);
      st.frame(2'h2, 5'h00, 16'h0000, d);
      chk({16'h0000, d}, {25'h0000000, (mode == xcvr_mgmt_pkg::MODE_KR) ? hs_rot[6:4] : hs_st,
          hs_rot[3:0]});
      st.frame(2'h3, 5'h00, 16'h0000, d);
      chk({16'h0000, d}, {16'h0000, v});
      stop_test();
   end
endmodule
